/* inc/fault_flags_pkg.sv */
package fault_flags_pkg;
	// Command codes of the event registers
	localparam logic [7:0] CMD_FAULT_VIEW = 8'h06;
	localparam logic [7:0] CMD_FAULT_CLEAR = 8'h07;
	localparam logic [7:0] CMD_START_VIEW = 8'h08;
	localparam logic [7:0] CMD_START_CLEAR = 8'h09;
	localparam logic [7:0] CMD_SUPPLY_VIEW = 8'h0a;
	localparam logic [7:0] CMD_SUPPLY_CLEAR = 8'h0b;
	// Reset values
	localparam logic [7:0] FAULT_RESET = 8'h00;
	localparam logic [7:0] START_RESET = 8'h00;
	localparam logic [7:0] SUPPLY_RESET = 8'h60;
	// Field positions
	localparam int HI_LSB = 4;
	localparam int LO_LSB = 0;
	localparam int SUP_THERMAL = 7;
	localparam int SUP_LOGIC_UV = 6;
	localparam int SUP_LOGIC_WARN = 5;
	localparam int SUP_POWER_UV = 4;
	localparam int SUP_SUM34 = 3;
	localparam int SUP_SUM12 = 2;
	localparam int SUP_SHUTDOWN = 1;
	localparam int SUP_MEMORY = 0;
	// Cool-down time and its cycle count at 125 MHz
	localparam int COOL_DOWN_MS = 1000;
	localparam int CLK_KHZ = 125000;
	localparam int COOL_DOWN_CYCLES = COOL_DOWN_MS * CLK_KHZ;

	// Per-channel event inputs for four channels, two two-channel port pairs
	typedef struct packed {
		logic [3:0] disconnect;
		logic [3:0] overload;
		logic [3:0] current_limit;
		logic [3:0] start_fault;
	} chan_events_s;

	typedef struct packed {
		logic thermal;
		logic logic_uv;
		logic logic_warn;
		logic power_uv;
		logic sum34;
		logic sum12;
		logic shutdown;
		logic memory;
	} supply_events_s;

	typedef struct packed {
		logic valid;
		logic [7:0] cmd;
	} read_req_s;
endpackage

/* src/poe_fault_event_flags.sv */
`timescale 1ns/100ps
// How it works
// - Disconnect/overload flags read at 06h, read-and-clear at 07h.
// - Current-limit/start flags read at 08h, read-and-clear at 09h.
// - Supply/fault flags read at 0Ah, read-and-clear at 0Bh.
// - Both aliases return same byte; only clear alias zeroes it.
// - Per-channel flags clear when that channel switches off.
// - Any set bit feeds interrupt summary; interrupt releases once clear reads leave all three registers zero.
// - Bits 7-4 disconnect ch4..1, bits 3-0 overload timeout; reset zero.
// - Four-pair ports set disconnect and overload flags per channel.
// - Single-signature disconnect sets both channels; dual-signature separate.
// - Host may re-power a dropped dual-signature channel via power-on bit.
// - Overload cutoff disabled keeps channel on, still flags after timeout.
// - Clearing overload flags leaves limit and overload timers untouched.
// - Bits 7-4 current-limit timeout, bits 3-0 start or discovery error.
// - Four-pair ports update limit and start flags per channel.
// - Start fault plus enable-change means inrush; else host reads 24h.
// - Autonomous mode suppresses start flags from invalid discovery.
// - Host may re-power a dual-signature channel after limit/start fault.
// - Class 6 or less single-signature: inrush on even channel only, then both marked power good.
// - Class 6 or less start fault: both off, cool-down, both flags.
// - Class 7-8: parallel inrush; any fault stops both, both flags set.
// - Dual-signature channels run inrush independently.
// - Supply register: thermal, logic UV, warn, power UV, sums, shutdown, memory.
// - Thermal shutdown turns every channel off.
module poe_fault_event_flags #(
	parameter int COOL_CYCLES = fault_flags_pkg::COOL_DOWN_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// Register read from the serial command decoder
	input wire fault_flags_pkg::read_req_s read_req,
	output logic [7:0] read_data,
	output logic read_valid,
	// Channel events, from same-clock supervisor logic
	input wire fault_flags_pkg::chan_events_s events,
	input wire fault_flags_pkg::supply_events_s supply_events,
	input wire logic autonomous_mode,
	input wire logic [3:0] discovery_invalid,
	// Channel state and four-pair inrush control
	input wire logic [3:0] channel_on,
	input wire logic [1:0] four_pair,
	input wire logic [1:0] single_signature,
	input wire logic [1:0] high_class,
	input wire logic [1:0] inrush_start,
	input wire logic [3:0] inrush_fault,
	output logic [3:0] channel_force_off,
	output logic [3:0] cool_down,
	output logic [3:0] power_good_flags,
	// Interrupt summary and pin
	output logic [2:0] event_summary,
	output logic int_b
);
	logic rst_meta_b;
	logic rst_sync_b;
	logic [7:0] fault_flags;
	logic [7:0] start_flags;
	logic [7:0] supply_flags;
	logic [3:0] disc_set;
	logic [3:0] start_set;
	logic [3:0] chan_off_edge;
	logic [3:0] channel_on_q;
	logic [3:0] inrush_stop;
	logic [3:0] inrush_ok;
	logic [3:0] inrush_active;
	logic [1:0] inrush_wait;
	logic [31:0] cool_count [4];
	logic clr_fault;
	logic clr_start;
	logic clr_supply;

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	// Clear strobes on the read-and-clear aliases
	assign clr_fault = read_req.valid && read_req.cmd == fault_flags_pkg::CMD_FAULT_CLEAR;
	assign clr_start = read_req.valid && read_req.cmd == fault_flags_pkg::CMD_START_CLEAR;
	assign clr_supply = read_req.valid && read_req.cmd == fault_flags_pkg::CMD_SUPPLY_CLEAR;

	// Channel turning off, including forced shutdowns
	assign chan_off_edge = channel_on_q & ~channel_on;

	// Spread a flag to both channels of each shared pair
	function automatic logic [3:0] pair_mirror(input logic [3:0] v, input logic [1:0] share);
		logic [3:0] r;
		r = v;
		if (share[0]) begin
			r[1:0] = {2{v[0] | v[1]}};
		end
		if (share[1]) begin
			r[3:2] = {2{v[2] | v[3]}};
		end
		return r;
	endfunction

	// Single-signature disconnect marks both channels
	assign disc_set = pair_mirror(events.disconnect, four_pair & single_signature);

	// Start flags: no report for invalid discovery in autonomous mode
	always_comb begin
		start_set = events.start_fault;
		if (autonomous_mode) begin
			start_set = start_set & ~discovery_invalid;
		end
		start_set = start_set | pair_mirror(inrush_stop, four_pair & single_signature);
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			channel_on_q <= 4'h0;
		end else begin
			channel_on_q <= channel_on;
		end
	end

	// Sets win over both clears; overload timers live outside and are never touched
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			fault_flags <= fault_flags_pkg::FAULT_RESET;
		end else begin
			fault_flags <= ((clr_fault ? 8'h00 : fault_flags) & ~{chan_off_edge, chan_off_edge})
				| {disc_set, events.overload};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			start_flags <= fault_flags_pkg::START_RESET;
		end else begin
			start_flags <= ((clr_start ? 8'h00 : start_flags) & ~{chan_off_edge, chan_off_edge})
				| {events.current_limit, start_set};
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			supply_flags <= fault_flags_pkg::SUPPLY_RESET;
		end else begin
			supply_flags <= (clr_supply ? 8'h00 : supply_flags) | supply_events;
		end
	end

	// Flag set, clear and channel-off behaviour
	chk_start_clear: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		clr_start && events == '0 && inrush_stop == 4'h0 && chan_off_edge == 4'h0
		|=> start_flags == 8'h00)
		else $error("start flags not cleared");

	chk_supply_clear: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		clr_supply && supply_events == '0 |=> supply_flags == 8'h00)
		else $error("supply flags not cleared");

	chk_fault_keeps: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		read_req.valid && read_req.cmd == fault_flags_pkg::CMD_FAULT_VIEW && events == '0
		&& chan_off_edge == 4'h0 |=> fault_flags == $past(fault_flags))
		else $error("fault view read changed flags");

	chk_overload_set: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		events.overload[2] |=> fault_flags[2])
		else $error("overload flag not set");

	chk_limit_set: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		events.current_limit[3] |=> start_flags[7])
		else $error("current limit flag not set");

	chk_thermal_flag: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		supply_events.thermal |=> supply_flags[fault_flags_pkg::SUP_THERMAL])
		else $error("thermal flag not set");

	chk_off_start: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		chan_off_edge[3] && !events.current_limit[3] && !start_set[3]
		|=> !start_flags[7] && !start_flags[3])
		else $error("start flags kept after channel off");

	chk_dual_disc: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		four_pair[1] && !single_signature[1] && events.disconnect[2] && !events.disconnect[3]
		&& !fault_flags[7] |=> fault_flags[6] && !fault_flags[7])
		else $error("dual signature disconnect spread");

	chk_ss_disc_hi: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		four_pair[1] && single_signature[1] && events.disconnect[3]
		|=> fault_flags[7:6] == 2'b11)
		else $error("single signature disconnect one bit");

	chk_two_pair_disc: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		!four_pair[0] && events.disconnect[0] && !events.disconnect[1] && !fault_flags[5]
		|=> !fault_flags[5])
		else $error("two-pair disconnect spread");

	chk_int_release: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		clr_fault && start_flags == 8'h00 && supply_flags == 8'h00 && events == '0
		&& supply_events == '0 && chan_off_edge == 4'h0 |=> int_b)
		else $error("clear read kept interrupt");

	// Read data returns the value held before any clear, and stands until the next request
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			read_data <= 8'h00;
			read_valid <= 1'b0;
		end else begin
			read_valid <= read_req.valid;
			if (read_req.valid) begin
				unique case (read_req.cmd)
					fault_flags_pkg::CMD_FAULT_VIEW, fault_flags_pkg::CMD_FAULT_CLEAR: begin
						read_data <= fault_flags;
					end
					fault_flags_pkg::CMD_START_VIEW, fault_flags_pkg::CMD_START_CLEAR: begin
						read_data <= start_flags;
					end
					fault_flags_pkg::CMD_SUPPLY_VIEW, fault_flags_pkg::CMD_SUPPLY_CLEAR: begin
						read_data <= supply_flags;
					end
					default: begin
						read_data <= 8'h00;
					end
				endcase
			end
		end
	end

	// Read answer timing and data
	chk_read_hold: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		!read_req.valid |=> $stable(read_data))
		else $error("read data moved without request");

	chk_valid_pulse: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		read_req.valid |=> read_valid)
		else $error("read answer missing");

	chk_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		read_req.valid && (read_req.cmd < fault_flags_pkg::CMD_FAULT_VIEW
		|| read_req.cmd > fault_flags_pkg::CMD_SUPPLY_CLEAR) |=> read_data == 8'h00)
		else $error("unmapped read returned data");

	chk_start_data: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		clr_start |=> read_data == $past(start_flags))
		else $error("start clear read wrong data");

	chk_supply_data: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		clr_supply |=> read_data == $past(supply_flags))
		else $error("supply clear read wrong data");

	chk_view_data: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		read_req.valid && read_req.cmd == fault_flags_pkg::CMD_FAULT_VIEW
		|=> read_data == $past(fault_flags))
		else $error("view read wrong data");

	assign event_summary = {|supply_flags, |start_flags, |fault_flags};
	assign int_b = ~|event_summary;

	// Inrush sequencing per four-pair port; even channel is primary
	always_comb begin
		inrush_stop = 4'h0;
		inrush_ok = 4'h0;
		for (int p = 0; p < 2; p++) begin
			if (four_pair[p] && single_signature[p] && inrush_active[2*p]) begin
				if (|inrush_fault[2*p +: 2]) begin
					inrush_stop[2*p +: 2] = 2'b11;
				end else if (inrush_start[p] == 1'b0 && inrush_wait[p]) begin
					inrush_ok[2*p +: 2] = 2'b11;
				end
			end else begin
				// Each channel stands alone, so a dropped one can be powered again
				inrush_stop[2*p +: 2] = inrush_fault[2*p +: 2] & inrush_active[2*p +: 2];
				if (inrush_start[p] == 1'b0 && inrush_wait[p]) begin
					inrush_ok[2*p +: 2] = inrush_active[2*p +: 2] & ~inrush_fault[2*p +: 2];
				end
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			inrush_active <= 4'h0;
			inrush_wait <= 2'b00;
			power_good_flags <= 4'h0;
			channel_force_off <= 4'h0;
		end else begin
			for (int p = 0; p < 2; p++) begin
				inrush_wait[p] <= inrush_start[p];
				if (inrush_start[p] && !inrush_wait[p]) begin
					inrush_active[2*p] <= 1'b1;
					inrush_active[2*p+1] <= !(single_signature[p] && !high_class[p]);
				end else begin
					inrush_active[2*p +: 2] <= inrush_active[2*p +: 2]
						& ~(inrush_ok[2*p +: 2] | inrush_stop[2*p +: 2]);
				end
			end
			power_good_flags <= (power_good_flags | inrush_ok) & ~inrush_stop & channel_on;
			channel_force_off <= inrush_stop | (supply_events.thermal ? 4'hf : 4'h0);
		end
	end

	// One-second cool-down after an inrush stop
	always_ff @(posedge clk_sys or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			for (int c = 0; c < 4; c++) begin
				cool_count[c] <= 32'h0;
			end
			cool_down <= 4'h0;
		end else begin
			for (int c = 0; c < 4; c++) begin
				if (inrush_stop[c]) begin
					cool_count[c] <= 32'(COOL_CYCLES);
				end else if (cool_count[c] != 32'h0) begin
					cool_count[c] <= cool_count[c] - 32'h1;
				end
				cool_down[c] <= inrush_stop[c] || cool_count[c] > 32'h1;
			end
		end
	end

	chk_clear_zeroes: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		clr_fault && events == '0 && chan_off_edge == 4'h0 |=> fault_flags == 8'h00)
		else $error("fault flags not cleared");
	chk_view_keeps: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		read_req.valid && read_req.cmd == fault_flags_pkg::CMD_START_VIEW && chan_off_edge == 4'h0
		&& start_set == 4'h0 && events.current_limit == 4'h0
		|=> start_flags == $past(start_flags))
		else $error("view read changed flags");
	chk_set_wins: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		clr_supply && supply_events.memory |=> supply_flags[fault_flags_pkg::SUP_MEMORY])
		else $error("event lost on clear");
	chk_read_data: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		clr_fault |=> read_valid && read_data == $past(fault_flags))
		else $error("clear read returned wrong data");
	chk_off_clears: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		chan_off_edge[0] && !events.overload[0] && !disc_set[0] |=> !fault_flags[0])
		else $error("flag kept after channel off");
	chk_int_follow: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		int_b == (fault_flags == 8'h00 && start_flags == 8'h00 && supply_flags == 8'h00))
		else $error("interrupt mismatch");
	chk_ss_disc: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		four_pair[0] && single_signature[0] && events.disconnect[0] |=> fault_flags[5:4] == 2'b11)
		else $error("single signature disconnect one bit");
	chk_auto_start: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		autonomous_mode && discovery_invalid[1] && !events.start_fault[1] && inrush_stop == 4'h0
		&& (clr_start || !start_flags[1]) |=> !start_flags[1])
		else $error("start flag from invalid discovery");
	chk_thermal_off: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		supply_events.thermal |=> channel_force_off == 4'hf)
		else $error("thermal did not turn channels off");
	chk_stop_cool: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		inrush_stop[0] |=> cool_down[0] && start_flags[0] && channel_force_off[0])
		else $error("inrush stop without cool-down");

	// Four-pair inrush sequencing
	chk_pg_ok: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		inrush_ok[0] && channel_on[0] |=> power_good_flags[0])
		else $error("power good not set after inrush");

	chk_second_idle: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		four_pair[0] && single_signature[0] && !high_class[0] && inrush_start[0]
		&& !inrush_wait[0] |=> !inrush_active[1])
		else $error("secondary ran inrush");

	chk_parallel: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		four_pair[1] && single_signature[1] && high_class[1] && inrush_start[1]
		&& !inrush_wait[1] |=> inrush_active[3:2] == 2'b11)
		else $error("class 7-8 inrush not parallel");

	chk_force_stop: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		inrush_stop[2] |=> channel_force_off[2] && cool_down[2])
		else $error("stopped channel left on");

	chk_dual_indep: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		four_pair[0] && !single_signature[0] && inrush_stop[1] && !inrush_fault[0]
		&& !supply_events.thermal |=> !channel_force_off[0])
		else $error("dual signature partner stopped");

	chk_cool_ends: assert property (@(posedge clk_sys) disable iff (!rst_sync_b)
		cool_count[0] == 32'h1 && !inrush_stop[0] |=> !cool_down[0])
		else $error("cool-down overran");

	cov_clear_read: cover property (@(posedge clk_sys) clr_fault && fault_flags != 8'h00);
	cov_dual_ok: cover property (@(posedge clk_sys) inrush_ok[0] && !inrush_ok[1]);
	cov_inrush_ok: cover property (@(posedge clk_sys) inrush_ok[0]);
	cov_inrush_stop: cover property (@(posedge clk_sys) inrush_stop[2]);
	cov_thermal: cover property (@(posedge clk_sys) supply_events.thermal);
endmodule // poe_fault_event_flags

/* test/host_reader.sv */
`timescale 1ns/100ps
module host_reader (
	// Clock
	input wire logic clk_sys,
	// Register read command and answer
	output fault_flags_pkg::read_req_s read_req,
	input wire logic [7:0] read_data,
	input wire logic read_valid
);
	logic [7:0] last_data;
	logic answered;

	initial begin
		read_req = '0;
		last_data = '0;
		answered = 1'b0;
	end

	// One command byte; answer taken at the edge after the request edge
	task automatic read_reg(input logic [7:0] cmd);
		@(posedge clk_sys);
		#1;
		read_req.valid = 1'b1;
		read_req.cmd = cmd;
		@(posedge clk_sys);
		#1;
		read_req.valid = 1'b0;
		// Released command bits no longer show the old code
		read_req.cmd = ~cmd;
		answered = read_valid;
		last_data = read_data;
	endtask
endmodule // host_reader

/* test/poe_fault_event_flags_tb_top.sv */
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("wrong value at %0t: got %h want %h", $time, a, b); end end
module poe_fault_event_flags_tb_top;
	typedef struct packed {
		logic [15:0] ev;
		logic [7:0] sup;
		logic [7:0] cmd;
		logic [7:0] exp;
	} row_s;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	fault_flags_pkg::read_req_s read_req;
	fault_flags_pkg::chan_events_s events = '0;
	fault_flags_pkg::supply_events_s supply_events = '0;
	logic autonomous_mode = 1'b0;
	logic [3:0] discovery_invalid = '0;
	logic [3:0] channel_on = 4'hf;
	logic [1:0] four_pair = 2'h3;
	logic [1:0] single_signature = 2'h3;
	logic [1:0] high_class = 2'h2;
	logic [1:0] inrush_start = '0;
	logic [3:0] inrush_fault = '0;
	logic [7:0] read_data;
	logic read_valid;
	logic [3:0] channel_force_off, cool_down, power_good_flags;
	logic [2:0] event_summary;
	logic int_b;
	int miscompares = 0;
	int total_checks = 0;
	row_s rows[13] = '{
		'{16'h1000, 8'h00, 8'h06, 8'h30},
		'{16'h0000, 8'h00, 8'h07, 8'h30},
		'{16'h0000, 8'h00, 8'h06, 8'h00},
		'{16'h0800, 8'h00, 8'h07, 8'h08},
		'{16'h0040, 8'h00, 8'h08, 8'h40},
		'{16'h0002, 8'h00, 8'h09, 8'h42},
		'{16'h0000, 8'h00, 8'h08, 8'h00},
		'{16'h0000, 8'h04, 8'h0a, 8'h04},
		'{16'h0000, 8'h01, 8'h0b, 8'h05},
		'{16'h0000, 8'h00, 8'h0a, 8'h00},
		'{16'hffff, 8'h00, 8'h0c, 8'h00},
		'{16'h0000, 8'h00, 8'h07, 8'hff},
		'{16'h0000, 8'h00, 8'h09, 8'hff}
	};

	poe_fault_event_flags #(.COOL_CYCLES(20)) poe_fault_event_flags_inst (.clk_sys, .rst_b,
		.read_req, .read_data, .read_valid, .events, .supply_events, .autonomous_mode,
		.discovery_invalid, .channel_on, .four_pair, .single_signature, .high_class,
		.inrush_start, .inrush_fault, .channel_force_off, .cool_down, .power_good_flags,
		.event_summary, .int_b);
	host_reader host_reader_inst (.clk_sys, .read_req, .read_data, .read_valid);

	initial begin
		forever #4 clk_sys = ~clk_sys;
	end

	task automatic complete_run();
		$display("checks %0d, miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic pulse(input logic [15:0] ev, input logic [7:0] sup);
		@(posedge clk_sys);
		#1;
		events = ev;
		supply_events = sup;
		@(posedge clk_sys);
		#1;
		events = '0;
		supply_events = '0;
	endtask

	task automatic rd(input logic [7:0] cmd, input logic [7:0] exp);
		host_reader_inst.read_reg(cmd);
		`CHK(host_reader_inst.answered, 1'b1)
		`CHK(host_reader_inst.last_data, exp)
	endtask

	// Inrush on one port, then read and clear the start flags
	task automatic inrush(input int p, input logic [3:0] f, input logic [7:0] exp);
		int n;
		@(posedge clk_sys);
		#1;
		inrush_start[p] = 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		inrush_start[p] = 1'b0;
		inrush_fault = f;
		for (n = 0; n < 20 && event_summary[1] !== 1'b1 && power_good_flags === 4'h0; n++)
			@(posedge clk_sys);
		#1;
		inrush_fault = '0;
		rd(8'h09, exp);
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys);
		miscompares++;
		complete_run();
	end

	initial begin
		int n;
		repeat (20) @(posedge clk_sys);
		#1;
		rst_b = 1'b1;
		repeat (4) @(posedge clk_sys);
		#1;
		`CHK(int_b, 1'b0)
		rd(8'h0a, 8'h60);
		rd(8'h0b, 8'h60);
		rd(8'h06, 8'h00);
		rd(8'h08, 8'h00);
		`CHK(int_b, 1'b1)
		`CHK(event_summary, 3'h0)
		foreach (rows[i]) begin
			if (rows[i].ev != '0 || rows[i].sup != '0) pulse(rows[i].ev, rows[i].sup);
			rd(rows[i].cmd, rows[i].exp);
		end
		pulse(16'h0100, 8'h00);
		`CHK(int_b, 1'b0)
		fork
			pulse(16'h0200, 8'h00);
			host_reader_inst.read_reg(8'h07);
		join
		`CHK(host_reader_inst.last_data, 8'h01)
		rd(8'h07, 8'h02);
		`CHK(int_b, 1'b1)
		pulse(16'h3333, 8'h00);
		channel_on = 4'he;
		rd(8'h06, 8'h22);
		rd(8'h09, 8'h22);
		channel_on = 4'hf;
		autonomous_mode = 1'b1;
		discovery_invalid = 4'h1;
		pulse(16'h0003, 8'h00);
		rd(8'h09, 8'h02);
		autonomous_mode = 1'b0;
		inrush(0, 4'h1, 8'h03);
		`CHK(cool_down, 4'h3)
		repeat (30) @(posedge clk_sys);
		#1;
		`CHK(cool_down, 4'h0)
		inrush(1, 4'h8, 8'h0c);
		`CHK(cool_down, 4'hc)
		single_signature = 2'h2;
		inrush(0, 4'h2, 8'h02);
		`CHK(power_good_flags[1:0], 2'h1)
		single_signature = 2'h3;
		repeat (30) @(posedge clk_sys);
		inrush(0, 4'h0, 8'h00);
		`CHK(power_good_flags[1:0], 2'h3)
		pulse(16'h0000, 8'h80);
		for (n = 0; n < 10 && channel_force_off !== 4'hf; n++)
			@(posedge clk_sys);
		#1;
		`CHK(channel_force_off, 4'hf)
		rd(8'h0b, 8'h80);
		complete_run();
	end
endmodule // poe_fault_event_flags_tb_top
